// file: core/crs_pkg.sv
package crs_pkg;

  // Array geometry: the serial register length and the number of image rows.
  localparam int          DIM_W        = 11;
  localparam logic [10:0] ARRAY_COLS   = 11'h400;
  localparam logic [10:0] ARRAY_ROWS   = 11'h400;

  // Converter word width.
  localparam int          PIX_W        = 16;

  // Clock, charge transfer and node reset times.
  localparam int          CLK_NS       = 40;
  localparam int          SER_SHIFT_NS = 480;
  localparam int          PAR_SHIFT_NS = 12000;
  localparam int          NODE_RST_NS  = 120;
  localparam logic [31:0] SER_CYC      =
    32'((SER_SHIFT_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [31:0] PAR_CYC      =
    32'((PAR_SHIFT_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [31:0] RST_CYC      =
    32'((NODE_RST_NS + CLK_NS - 1) / CLK_NS);

  // Output amplifier selection, which fixes the serial direction.
  localparam logic        AMP_LOW_NOISE = 1'b0;
  localparam logic        DIR_LEFT      = 1'b0;
  localparam logic        DIR_RIGHT     = 1'b1;

  typedef enum logic [2:0] {
    CRS_IDLE   = 3'h0,
    CRS_EXPOSE = 3'h1,
    CRS_COMP   = 3'h2,
    CRS_PAR    = 3'h3,
    CRS_SER    = 3'h4,
    CRS_CONV   = 3'h5,
    CRS_DUMP   = 3'h6
  } crs_state_e;

  typedef struct packed {
    logic        binned;
    logic        amp_sel;
    logic [1:0]  gain;
    logic [10:0] bin_x;
    logic [10:0] bin_y;
    logic [10:0] roi_x0;
    logic [10:0] roi_y0;
    logic [10:0] roi_w;
    logic [10:0] roi_h;
    logic [31:0] exp_cyc;
    logic [31:0] comp_cyc;
  } crs_cfg_s;

  typedef struct packed {
    logic        par_clk;
    logic        ser_clk;
    logic        ser_dir;
    logic        node_rst;
    logic        adc_start;
    logic        amp_sel;
    logic [1:0]  gain;
  } crs_ccd_s;

  typedef struct packed {
    logic        valid;
    logic        sof;
    logic        sol;
    logic        eof;
    logic [15:0] data;
  } crs_pix_s;

endpackage : crs_pkg

// file: core/crs_timer.sv
`timescale 1ns/1ps
`default_nettype none

// Down counter: load starts an interval, done pulses as its last cycle ends.
module crs_timer (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // Control
  input  wire logic        load,
  input  wire logic [31:0] load_val,
  // Status
  output logic             done
);

  logic [31:0] cnt;
  wire  [31:0] start_val = (load_val == 32'h0) ? 32'h1 : load_val;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cnt <= 32'h0;
    end else if (load) begin
      cnt <= start_val;
    end else if (cnt != 32'h0) begin
      cnt <= cnt - 32'h1;
    end
  end

  // Done must not look at load, since the caller forms load from done.
  assign done = (cnt == 32'h1);

endmodule : crs_timer

`default_nettype wire

// file: core/crs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none

module crs_sequencer (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             srst,
  // Frame control
  input  wire logic             start,
  input  wire crs_pkg::crs_cfg_s cfg,
  // Converter answer
  input  wire logic             adc_done,
  input  wire logic [15:0]      adc_data,
  // Array drive
  output crs_pkg::crs_ccd_s     ccd,
  // Pixel stream to the host
  output crs_pkg::crs_pix_s     pix,
  // Status
  output logic                  busy,
  output logic                  not_scan,
  output logic                  array_clear,
  output logic                  frame_done
);

  crs_pkg::crs_state_e state;
  crs_pkg::crs_state_e next_state;
  crs_pkg::crs_cfg_s   cur;

  logic [10:0] row_cnt;
  logic [10:0] col_cnt;
  logic [10:0] rb;
  logic [10:0] cb;
  logic [10:0] sr_row;
  logic [10:0] sc_col;
  logic        first_px;
  logic        row_first;
  logic        tmr_done;
  logic        tmr_load;
  logic [31:0] tmr_val;

  // Full-frame mode forces unit bins so each pixel is converted alone.
  wire [10:0] eff_bx = (!cur.binned || cur.bin_x == 11'h0) ? 11'h1 : cur.bin_x;
  wire [10:0] eff_by = (!cur.binned || cur.bin_y == 11'h0) ? 11'h1 : cur.bin_y;

  wire        last_row  = (row_cnt == crs_pkg::ARRAY_ROWS);
  wire        last_col  = (col_cnt == crs_pkg::ARRAY_COLS);
  wire        row_full  = (rb + 11'h1 == eff_by) ||
                          (row_cnt + 11'h1 == crs_pkg::ARRAY_ROWS);
  wire        bin_full  = (cb + 11'h1 == eff_bx) ||
                          (col_cnt + 11'h1 == crs_pkg::ARRAY_COLS);

  // Region test on the first physical pixel of the super pixel.
  wire [11:0] x_end     = {1'b0, cur.roi_x0} + {1'b0, cur.roi_w};
  wire [11:0] y_end     = {1'b0, cur.roi_y0} + {1'b0, cur.roi_h};
  wire        in_x      = (sc_col >= cur.roi_x0) && ({1'b0, sc_col} < x_end);
  wire        in_y      = (sr_row >= cur.roi_y0) && ({1'b0, sr_row} < y_end);
  wire        in_roi    = in_x && in_y;

  wire        start_ok  = start && (state == crs_pkg::CRS_IDLE);
  wire        pix_end   = (state == crs_pkg::CRS_CONV && adc_done) ||
                          (state == crs_pkg::CRS_DUMP && tmr_done);

  always_comb begin
    next_state = state;
    unique case (state)
      crs_pkg::CRS_IDLE: begin
        if (start) begin
          next_state = crs_pkg::CRS_EXPOSE;
        end
      end
      crs_pkg::CRS_EXPOSE: begin
        if (tmr_done) begin
          next_state = crs_pkg::CRS_COMP;
        end
      end
      crs_pkg::CRS_COMP: begin
        if (tmr_done) begin
          next_state = crs_pkg::CRS_PAR;
        end
      end
      crs_pkg::CRS_PAR: begin
        if (tmr_done && row_full) begin
          next_state = crs_pkg::CRS_SER;
        end
      end
      crs_pkg::CRS_SER: begin
        if (tmr_done && bin_full) begin
          next_state = in_roi ? crs_pkg::CRS_CONV
                              : crs_pkg::CRS_DUMP;
        end
      end
      crs_pkg::CRS_CONV, crs_pkg::CRS_DUMP: begin
        if (pix_end) begin
          if (!last_col) begin
            next_state = crs_pkg::CRS_SER;
          end else if (!last_row) begin
            next_state = crs_pkg::CRS_PAR;
          end else begin
            next_state = crs_pkg::CRS_IDLE;
          end
        end
      end
      default: begin
        next_state = crs_pkg::CRS_IDLE;
      end
    endcase
  end

  // The timer restarts on every state change and on each repeated shift.
  assign tmr_load = (next_state != state) ||
                    (tmr_done && (state == crs_pkg::CRS_PAR ||
                                  state == crs_pkg::CRS_SER));

  always_comb begin
    unique case (next_state)
      crs_pkg::CRS_EXPOSE: tmr_val = start_ok ? cfg.exp_cyc : cur.exp_cyc;
      crs_pkg::CRS_COMP:   tmr_val = cur.comp_cyc;
      crs_pkg::CRS_PAR:    tmr_val = crs_pkg::PAR_CYC;
      crs_pkg::CRS_SER:    tmr_val = crs_pkg::SER_CYC;
      crs_pkg::CRS_DUMP:   tmr_val = crs_pkg::RST_CYC;
      default:             tmr_val = 32'h0;
    endcase
  end

  crs_timer u_timer (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .load     (tmr_load),
    .load_val (tmr_val),
    .done     (tmr_done)
  );

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state <= crs_pkg::CRS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Settings are frozen for the whole frame.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cur <= '0;
    end else if (start_ok) begin
      cur <= cfg;
    end
  end

  // Physical row and column positions and the bin sub-counts.
  always_ff @(posedge sys_clk) begin
    if (srst || start_ok) begin
      row_cnt <= 11'h0;
      rb      <= 11'h0;
      sr_row  <= 11'h0;
    end else if (state == crs_pkg::CRS_PAR && tmr_done) begin
      row_cnt <= row_cnt + 11'h1;
      rb      <= row_full ? 11'h0 : rb + 11'h1;
    end else if (pix_end && last_col) begin
      sr_row  <= row_cnt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst || (state == crs_pkg::CRS_PAR)) begin
      col_cnt <= 11'h0;
      cb      <= 11'h0;
      sc_col  <= 11'h0;
    end else if (state == crs_pkg::CRS_SER && tmr_done) begin
      col_cnt <= col_cnt + 11'h1;
      cb      <= bin_full ? 11'h0 : cb + 11'h1;
    end else if (pix_end) begin
      sc_col  <= col_cnt;
    end
  end

  // Registered drive to the array, the converter and the preamplifier.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ccd <= '0;
    end else begin
      ccd.par_clk   <= (next_state == crs_pkg::CRS_PAR);
      ccd.ser_clk   <= (next_state == crs_pkg::CRS_SER);
      ccd.ser_dir   <= (cur.amp_sel == crs_pkg::AMP_LOW_NOISE)
                       ? crs_pkg::DIR_LEFT : crs_pkg::DIR_RIGHT;
      // Aligned with par_clk so the node is free for the first serial shift.
      ccd.node_rst  <= (next_state == crs_pkg::CRS_DUMP) ||
                       (next_state == crs_pkg::CRS_PAR);
      ccd.adc_start <= (next_state == crs_pkg::CRS_CONV) &&
                       (state != crs_pkg::CRS_CONV);
      ccd.amp_sel   <= cur.amp_sel;
      ccd.gain      <= cur.gain;
    end
  end

  // Stream flags follow the conversions as they leave the node.
  always_ff @(posedge sys_clk) begin
    if (srst || start_ok) begin
      first_px  <= 1'b1;
      row_first <= 1'b1;
    end else if (state == crs_pkg::CRS_CONV && adc_done) begin
      first_px  <= 1'b0;
      row_first <= last_col;
    end else if (pix_end && last_col) begin
      row_first <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pix <= '0;
    end else begin
      pix.valid <= (state == crs_pkg::CRS_CONV) && adc_done;
      pix.sof   <= (state == crs_pkg::CRS_CONV) && adc_done && first_px;
      pix.sol   <= (state == crs_pkg::CRS_CONV) && adc_done && row_first;
      pix.eof   <= (state == crs_pkg::CRS_CONV) && adc_done &&
                   (next_state == crs_pkg::CRS_IDLE);
      pix.data  <= adc_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      busy        <= 1'b0;
      not_scan    <= 1'b1;
      array_clear <= 1'b0;
      frame_done  <= 1'b0;
    end else begin
      busy       <= (next_state != crs_pkg::CRS_IDLE);
      not_scan   <= (next_state == crs_pkg::CRS_IDLE) ||
                    (next_state == crs_pkg::CRS_EXPOSE) ||
                    (next_state == crs_pkg::CRS_COMP);
      frame_done <= pix_end && (next_state == crs_pkg::CRS_IDLE);
      // Reading every row out empties the wells, so no clean pass is owed.
      if (pix_end && next_state == crs_pkg::CRS_IDLE) begin
        array_clear <= 1'b1;
      end else if (start_ok) begin
        array_clear <= 1'b0;
      end
    end
  end

endmodule : crs_sequencer

`default_nettype wire

// file: tb/crs_sequencer_props.sv
`timescale 1ns/1ps
`default_nettype none
module crs_sequencer_props (
  // Clock and reset
  input wire logic              sys_clk,
  input wire logic              srst,
  // Watched ports
  input wire logic              start,
  input wire logic              adc_done,
  input wire logic [15:0]       adc_data,
  input wire crs_pkg::crs_ccd_s ccd,
  input wire crs_pkg::crs_pix_s pix,
  input wire logic              busy,
  input wire logic              not_scan,
  input wire logic              array_clear
);
  logic [11:0] par_run;
  logic [11:0] ser_run;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // Runs are judged when they end, since binning stretches them.
  always_ff @(posedge sys_clk) begin
    par_run <= (srst || !ccd.par_clk) ? 12'h000 : par_run + 12'h001;
    ser_run <= (srst || !ccd.ser_clk) ? 12'h000 : ser_run + 12'h001;
  end
  a_par_run_len:
    assert property ($fell(ccd.par_clk) |-> par_run != 12'h000 &&
      par_run % 12'(crs_pkg::PAR_CYC) == 12'h000) else $error("bad line run");
  a_ser_run_len:
    assert property ($fell(ccd.ser_clk) |-> ser_run != 12'h000 &&
      ser_run % 12'(crs_pkg::SER_CYC) == 12'h000) else $error("bad shift run");
  a_par_ser_apart:
    assert property (!(ccd.par_clk && ccd.ser_clk)) else $error("overlap");
  a_conv_single:
    assert property (ccd.adc_start |-> !ccd.ser_clk ##1 !ccd.adc_start)
      else $error("bad conversion start");
  a_dir_follows_amp:
    assert property (ccd.ser_clk |-> ccd.ser_dir == (ccd.amp_sel ==
      crs_pkg::AMP_LOW_NOISE ? crs_pkg::DIR_LEFT : crs_pkg::DIR_RIGHT))
      else $error("wrong shift direction");
  a_start_taken:
    assert property (start && !busy |=> busy && !array_clear)
      else $error("start not taken");
  a_scan_low_readout:
    assert property (ccd.par_clk || ccd.ser_clk |-> !not_scan)
      else $error("not_scan high in readout");
  a_pix_after_done:
    assert property (pix.valid |-> $past(adc_done) &&
      pix.data == $past(adc_data)) else $error("pixel not from converter");
  a_sof_marks_row:
    assert property (pix.sof |-> pix.valid && pix.sol) else $error("bad sof");
  a_node_rst_apart:
    assert property (ccd.node_rst |-> !ccd.ser_clk && !ccd.adc_start)
      else $error("node reset during shift or conversion");
  a_node_rst_line:
    assert property (ccd.par_clk |-> ccd.node_rst)
      else $error("node not cleared in line transfer");
  c_line: cover property ($fell(ccd.par_clk));
  c_sof: cover property (pix.sof);
  c_right: cover property (ccd.ser_clk && ccd.ser_dir);
endmodule : crs_sequencer_props
`default_nettype wire

// file: tb/crs_ccd_model.sv
`timescale 1ns/1ps
`default_nettype none
// Converter answers after one to sixteen cycles, so slow and prompt
// answers both occur; between answers the data bus toggles.
module crs_ccd_model (
  // Clock and reset
  input  wire logic   sys_clk,
  input  wire logic   srst,
  // Converter
  input  wire logic   adc_start,
  output logic        adc_done,
  output logic [15:0] adc_data,
  // Note of each delivered word
  output logic        note,
  output logic [15:0] note_data
);
  int          wait_cnt = 0;
  logic [15:0] word;
  always @(negedge sys_clk) begin
    if (srst) begin
      wait_cnt  <= 0;
      adc_done  <= 1'b0;
      adc_data  <= 16'h0000;
      note      <= 1'b0;
      note_data <= 16'h0000;
    end else begin
      adc_done <= (wait_cnt == 1);
      note     <= (wait_cnt == 1);
      adc_data <= (wait_cnt == 1) ? word : ~adc_data;
      if (wait_cnt == 1) begin
        note_data <= word;
      end
      if (adc_start) begin
        wait_cnt <= 1 + int'($urandom % 16);
        word     <= 16'($urandom);
      end else if (wait_cnt > 0) begin
        wait_cnt <= wait_cnt - 1;
      end
    end
  end
endmodule : crs_ccd_model
`default_nettype wire

// file: tb/crs_sequencer_bench.sv
`timescale 1ns/1ps
`default_nettype none
module crs_sequencer_bench;
  logic              sys_clk;
  logic              srst = 1'b1;
  logic              start = 1'b0;
  crs_pkg::crs_cfg_s cfg = '0;
  logic              adc_done;
  logic [15:0]       adc_data;
  crs_pkg::crs_ccd_s ccd;
  crs_pkg::crs_pix_s pix;
  logic              busy;
  logic              not_scan;
  logic              array_clear;
  logic              frame_done;
  logic              note;
  logic [15:0]       note_data;
  logic [17:0]       exp_q[$];
  logic [18:0]       seen_word;
  int err_count = 0, checks = 0, cycles = 0, sent = 0, seen = 0, row_w = 1;

  crs_sequencer u_dut (.sys_clk(sys_clk), .srst(srst), .start(start),
    .cfg(cfg), .adc_done(adc_done), .adc_data(adc_data), .ccd(ccd),
    .pix(pix), .busy(busy), .not_scan(not_scan),
    .array_clear(array_clear), .frame_done(frame_done));
  crs_ccd_model u_model (.sys_clk(sys_clk), .srst(srst),
    .adc_start(ccd.adc_start), .adc_done(adc_done), .adc_data(adc_data),
    .note(note), .note_data(note_data));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask : check

  task close_out;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      close_out;
    end
    if (note) begin
      exp_q.push_back({sent == 0, sent % row_w == 0, note_data});
      sent++;
    end
    if (pix.valid) begin
      seen++;
      // Frames here are cut short by reset, so no end-of-frame mark is due.
      seen_word = {pix.eof, pix.sof, pix.sol, pix.data};
      if (exp_q.size() == 0) begin
        check(32'h1, 32'h0);
      end else begin
        check(seen_word, exp_q.pop_front());
      end
    end
  end

  // One frame up to its first outputs, then an abort by reset.
  task run_frame(input logic bin, input logic amp, input logic [10:0] b,
      input logic [10:0] x0, input logic [10:0] w, input int n_out,
      input logic [31:0] par_exp, input logic [31:0] ser_exp, input int rw);
    int n;
    logic [1:0] g;
    sent = 0;
    seen = 0;
    row_w = rw;
    cfg = '0;
    cfg.binned = bin;
    cfg.amp_sel = amp;
    g = 2'($urandom);
    cfg.gain = g;
    cfg.bin_x = b;
    cfg.bin_y = b;
    cfg.roi_x0 = x0;
    cfg.roi_w = w;
    cfg.roi_h = 11'h002;
    cfg.exp_cyc = 32'h2;
    cfg.comp_cyc = 32'h2;
    start = 1'b1;
    @(negedge sys_clk);
    start = 1'b0;
    cfg.amp_sel = ~amp;
    cfg.binned = ~bin;
    cfg.roi_x0 = 11'($urandom);
    cfg.gain = ~g;
    while (!ccd.par_clk) @(negedge sys_clk);
    n = 0;
    while (ccd.par_clk) begin
      n++;
      @(negedge sys_clk);
    end
    check(n, par_exp);
    while (!ccd.ser_clk) @(negedge sys_clk);
    check(ccd.ser_dir, amp ? crs_pkg::DIR_RIGHT : crs_pkg::DIR_LEFT);
    check(ccd.amp_sel, amp);
    check(ccd.gain, g);
    n = 0;
    while (ccd.ser_clk) begin
      n++;
      @(negedge sys_clk);
    end
    check(n, ser_exp);
    while (seen < n_out) @(negedge sys_clk);
    check(exp_q.size(), 0);
    srst = 1'b1;
    repeat (3) @(negedge sys_clk);
    check({busy, not_scan, array_clear, frame_done}, 4'h4);
    exp_q.delete();
    srst = 1'b0;
    @(negedge sys_clk);
    $display("frame test done, binned %0d", bin);
  endtask : run_frame

  initial begin
    void'($urandom(32'h6d0e));
    repeat (16) @(negedge sys_clk);
    srst = 1'b0;
    run_frame(1'b0, 1'b0, 11'h001, 11'h002, 11'h003, 6,
      crs_pkg::PAR_CYC, crs_pkg::SER_CYC, 3);
    run_frame(1'b1, 1'b1, 11'h002, 11'h000, 11'h004, 2,
      crs_pkg::PAR_CYC * 2, crs_pkg::SER_CYC * 2, 2);
    close_out;
  end
endmodule : crs_sequencer_bench

bind crs_sequencer crs_sequencer_props u_props (.sys_clk(sys_clk),
  .srst(srst), .start(start), .adc_done(adc_done), .adc_data(adc_data),
  .ccd(ccd), .pix(pix), .busy(busy), .not_scan(not_scan),
  .array_clear(array_clear));
`default_nettype wire
